// ===== asm_dev.sv
// signature module end of the pod bus: control, gate, crc, events, waveform
`timescale 1ns/1ps
`default_nettype none
module asm_dev #(
  parameter int DEPTH = asm_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pod bus
  asm_pod_if.dev pod,
  // probe and clock module
  input wire logic probe_data_i,
  input wire logic ck_clock_i,
  input wire logic ck_start_i,
  input wire logic ck_stop_i,
  input wire logic ck_enable_i,
  input wire logic pod_sync_i,
  // status
  output logic pod_isolate_o,
  output logic gate_open_o,
  output logic [asm_pkg::DLY_W-1:0] delay_sel_o
);
  import asm_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic sel_q, sel_d;
  logic en_high_q, en_high_d, en_low_q, en_low_d;
  logic clk_sync_q, clk_sync_d, clk_fall_q, clk_fall_d;
  logic edge_ok_q, edge_ok_d;
  logic start_sync_q, start_sync_d, start_fall_q, start_fall_d;
  logic stop_sync_q, stop_sync_d, stop_fall_q, stop_fall_d;
  logic soc_en_q, soc_en_d;
  logic [DLY_W-1:0] dly_q, dly_d;
  logic [SOC_W-1:0] soc_q, soc_d, gcnt_q, gcnt_d;
  asm_rsel_e rsel_q, rsel_d;
  asm_gate_e gate_q, gate_d;
  logic [SIG_W-1:0] sig_q, sig_d;
  logic [EVT_W-1:0] evt_q, evt_d;
  logic [WAVE_W-1:0] wave_q, wave_d;
  logic clk_p_q, start_p_q, stop_p_q;

  // ****************************************************************
  // edges and gating
  // ****************************************************************
  logic clk_src, start_src, stop_src, en_ok;
  logic clk_edge, start_edge, stop_edge, gclk, soc_hit;

  function automatic logic edge_of(input logic cur, input logic prev,
                                   input logic fall);
    edge_of = fall ? (prev & ~cur) : (~prev & cur);
  endfunction : edge_of

  assign clk_src = clk_sync_q ? pod_sync_i : ck_clock_i;
  assign start_src = start_sync_q ? pod_sync_i : ck_start_i;
  assign stop_src = stop_sync_q ? pod_sync_i : ck_stop_i;
  // falling clock edge only once edge choice is permitted
  assign clk_edge = edge_of(clk_src, clk_p_q, clk_fall_q & edge_ok_q);
  assign start_edge = edge_of(start_src, start_p_q, start_fall_q);
  assign stop_edge = edge_of(stop_src, stop_p_q, stop_fall_q);
  assign en_ok = en_high_q | (ck_enable_i ^ en_low_q);
  assign gclk = (gate_q == GS_OPEN) & clk_edge & en_ok;
  assign soc_hit = soc_en_q & gclk & (gcnt_q + SOC_W'(1) == soc_q);

  // ****************************************************************
  // op code path and read buffer
  // ****************************************************************
  logic op_take, push_v, push_rdy, is_push;
  logic [NIB_W-1:0] push_nib, status_nib;
  logic [7:0] op;

  assign op = pod.op_code;
  assign is_push = sel_q & ((op == OP_STATUS) | (op == OP_STEP));
  // reads stall the bus while the buffer is full
  assign pod.op_ready = ~is_push | push_rdy;
  assign op_take = pod.op_valid & pod.op_ready;
  assign push_v = pod.op_valid & is_push;
  assign status_nib = {gate_q == GS_OPEN, gate_q == GS_DONE,
                       gate_q == GS_ARMED, sel_q};

  always_comb begin
    push_nib = status_nib;
    if (op == OP_STEP) begin
      case (rsel_q)
        RS_SIG: push_nib = sig_q[SIG_W-1 -: NIB_W];
        RS_EVT: push_nib = evt_q[EVT_W-1 -: NIB_W];
        RS_WAVE: push_nib = wave_q[WAVE_RD_W-1 -: NIB_W];
        default: push_nib = '0;
      endcase
    end
  end

  asm_fifo #(.W(NIB_W), .D(DEPTH)) u_rdbuf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_v),
    .in_ready_o(push_rdy),
    .in_data_i(push_nib),
    .out_valid_o(pod.rd_valid),
    .out_ready_i(pod.rd_ready),
    .out_data_o(pod.rd_data)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    sel_d = sel_q;
    en_high_d = en_high_q;
    en_low_d = en_low_q;
    clk_sync_d = clk_sync_q;
    clk_fall_d = clk_fall_q;
    edge_ok_d = edge_ok_q;
    start_sync_d = start_sync_q;
    start_fall_d = start_fall_q;
    stop_sync_d = stop_sync_q;
    stop_fall_d = stop_fall_q;
    soc_en_d = soc_en_q;
    dly_d = dly_q;
    soc_d = soc_q;
    rsel_d = rsel_q;
    gate_d = gate_q;
    sig_d = sig_q;
    evt_d = evt_q;
    wave_d = wave_q;
    gcnt_d = gcnt_q;
    // measurement sections
    if (gate_q == GS_OPEN) begin
      wave_d = {wave_q[WAVE_W-2:0], probe_data_i};
    end
    if (gclk) begin
      sig_d = {sig_q[SIG_W-2:0], probe_data_i ^ (^(sig_q & SIG_TAPS))};
      if (evt_q != EVT_MAX) begin
        evt_d = evt_q + EVT_W'(1);
      end
      gcnt_d = gcnt_q + SOC_W'(1);
    end
    case (gate_q)
      GS_ARMED: if (start_edge) gate_d = GS_OPEN;
      GS_OPEN: if (stop_edge | soc_hit) gate_d = GS_DONE;
      GS_IDLE, GS_DONE: gate_d = gate_q;
      default: gate_d = GS_IDLE;
    endcase
    // commands
    if (op_take && !sel_q) begin
      if (op == OP_ON && pod.host_select_strobe) begin
        sel_d = 1'b1;
      end
    end else if (op_take) begin
      case (op)
        OP_OFF: sel_d = 1'b0;
        OP_EN_MOD: en_high_d = 1'b0;
        OP_EN_HIGH: en_high_d = 1'b1;
        OP_CLK_MOD: clk_sync_d = 1'b0;
        OP_CLK_SYNC: clk_sync_d = 1'b1;
        OP_START_MOD: start_sync_d = 1'b0;
        OP_START_SYNC: start_sync_d = 1'b1;
        OP_STOP_MOD: stop_sync_d = 1'b0;
        OP_STOP_SYNC: stop_sync_d = 1'b1;
        OP_EN_LVL_HI: en_low_d = 1'b0;
        OP_EN_LVL_LO: en_low_d = 1'b1;
        OP_CLK_RISE: clk_fall_d = 1'b0;
        OP_CLK_FALL: clk_fall_d = 1'b1;
        OP_START_RISE: start_fall_d = 1'b0;
        OP_START_FALL: start_fall_d = 1'b1;
        OP_STOP_RISE: stop_fall_d = 1'b0;
        OP_STOP_FALL: stop_fall_d = 1'b1;
        OP_EDGE_OK: edge_ok_d = 1'b1;
        OP_DISARM: begin
          if (gate_q == GS_ARMED) gate_d = GS_IDLE;
        end
        OP_ARM: begin
          if (gate_q == GS_IDLE) gate_d = GS_ARMED;
        end
        OP_SOC_OFF: soc_en_d = 1'b0;
        OP_SOC_ON: soc_en_d = 1'b1;
        OP_RD_SIG: rsel_d = RS_SIG;
        OP_RD_EVT: rsel_d = RS_EVT;
        OP_RD_WAVE: rsel_d = RS_WAVE;
        OP_STEP: begin
          // all three shift together; host picks one by the select
          sig_d = {sig_q[SIG_W-NIB_W-1:0], NIB_W'(0)};
          evt_d = {evt_q[EVT_W-NIB_W-1:0], NIB_W'(0)};
          wave_d = {wave_q[WAVE_W-NIB_W-1:0], NIB_W'(0)};
        end
        OP_CLR_SIG: sig_d = SIG_RST;
        OP_CLR_EVT: evt_d = '0;
        OP_CLR_WAVE: wave_d = '0;
        OP_CLR_GATE: begin
          gate_d = GS_IDLE;
          gcnt_d = '0;
        end
        default: begin
          if (op[7:4] == OP_DLY_HI && !op[3]) begin
            dly_d[op[2:1]] = op[0];
          end else if (op[7:4] == OP_SOC_LO) begin
            soc_d[3:0] = op[3:0];
          end else if (op[7:4] == OP_SOC_MID) begin
            soc_d[7:4] = op[3:0];
          end else if (op[7:4] == OP_SOC_HI) begin
            soc_d[11:8] = op[3:0];
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sel_q <= 1'b0;
      en_high_q <= 1'b0;
      en_low_q <= 1'b0;
      clk_sync_q <= 1'b0;
      clk_fall_q <= 1'b0;
      edge_ok_q <= 1'b0;
      start_sync_q <= 1'b0;
      start_fall_q <= 1'b0;
      stop_sync_q <= 1'b0;
      stop_fall_q <= 1'b0;
      soc_en_q <= 1'b0;
      dly_q <= '0;
      soc_q <= '0;
      rsel_q <= RS_SIG;
      gate_q <= GS_IDLE;
      sig_q <= SIG_RST;
      evt_q <= '0;
      wave_q <= '0;
      gcnt_q <= '0;
      clk_p_q <= 1'b0;
      start_p_q <= 1'b0;
      stop_p_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      en_high_q <= en_high_d;
      en_low_q <= en_low_d;
      clk_sync_q <= clk_sync_d;
      clk_fall_q <= clk_fall_d;
      edge_ok_q <= edge_ok_d;
      start_sync_q <= start_sync_d;
      start_fall_q <= start_fall_d;
      stop_sync_q <= stop_sync_d;
      stop_fall_q <= stop_fall_d;
      soc_en_q <= soc_en_d;
      dly_q <= dly_d;
      soc_q <= soc_d;
      rsel_q <= rsel_d;
      gate_q <= gate_d;
      sig_q <= sig_d;
      evt_q <= evt_d;
      wave_q <= wave_d;
      gcnt_q <= gcnt_d;
      clk_p_q <= clk_src;
      start_p_q <= start_src;
      stop_p_q <= stop_src;
    end
  end

  assign pod_isolate_o = sel_q;
  assign pod.pod_side_handshake = sel_q;
  assign gate_open_o = (gate_q == GS_OPEN);
  assign delay_sel_o = dly_q;
endmodule : asm_dev
`default_nettype wire

// ===== asm_pkg.sv
// constants, op codes and types shared by both ends of the signature link
`default_nettype none
package asm_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int OP_W = 8;
  localparam int NIB_W = 4;
  localparam int SIG_W = 16;
  localparam int EVT_W = 24;
  localparam int SOC_W = 12;
  localparam int DLY_W = 4;
  localparam int FIFO_DEPTH = 8;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int WAVE_NS = 640;
  // history must cover the whole span, so round up
  localparam int WAVE_W = (WAVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAVE_RD_W = 64;
  // ****************************************************************
  // values
  // ****************************************************************
  localparam logic [SIG_W-1:0] SIG_TAPS = 16'h8940;
  localparam logic [SIG_W-1:0] SIG_RST = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_MAX = 24'hFFFFFF;
  // ****************************************************************
  // op codes
  // ****************************************************************
  localparam logic [7:0] OP_ON = 8'h00;
  localparam logic [7:0] OP_OFF = 8'hF0;
  localparam logic [7:0] OP_EN_MOD = 8'h10;
  localparam logic [7:0] OP_EN_HIGH = 8'h11;
  localparam logic [7:0] OP_CLK_MOD = 8'h12;
  localparam logic [7:0] OP_CLK_SYNC = 8'h13;
  localparam logic [7:0] OP_START_MOD = 8'h14;
  localparam logic [7:0] OP_START_SYNC = 8'h15;
  localparam logic [7:0] OP_STOP_MOD = 8'h16;
  localparam logic [7:0] OP_STOP_SYNC = 8'h17;
  localparam logic [7:0] OP_EN_LVL_HI = 8'h18;
  localparam logic [7:0] OP_EN_LVL_LO = 8'h19;
  localparam logic [7:0] OP_CLK_RISE = 8'h1A;
  localparam logic [7:0] OP_CLK_FALL = 8'h1B;
  localparam logic [7:0] OP_START_RISE = 8'h1C;
  localparam logic [7:0] OP_START_FALL = 8'h1D;
  localparam logic [7:0] OP_STOP_RISE = 8'h1E;
  localparam logic [7:0] OP_STOP_FALL = 8'h1F;
  localparam logic [3:0] OP_DLY_HI = 4'h2;
  localparam logic [7:0] OP_DISARM = 8'h28;
  localparam logic [7:0] OP_ARM = 8'h29;
  localparam logic [7:0] OP_SOC_OFF = 8'h2A;
  localparam logic [7:0] OP_SOC_ON = 8'h2B;
  localparam logic [7:0] OP_EDGE_OK = 8'h30;
  localparam logic [3:0] OP_SOC_LO = 4'h5;
  localparam logic [3:0] OP_SOC_MID = 4'h6;
  localparam logic [3:0] OP_SOC_HI = 4'h7;
  localparam logic [7:0] OP_STATUS = 8'h80;
  localparam logic [7:0] OP_RD_SIG = 8'h81;
  localparam logic [7:0] OP_RD_EVT = 8'h82;
  localparam logic [7:0] OP_RD_WAVE = 8'h83;
  localparam logic [7:0] OP_STEP = 8'h90;
  localparam logic [7:0] OP_CLR_SIG = 8'hB0;
  localparam logic [7:0] OP_CLR_EVT = 8'hC0;
  localparam logic [7:0] OP_CLR_WAVE = 8'hD0;
  localparam logic [7:0] OP_CLR_GATE = 8'hE0;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {GS_IDLE, GS_ARMED, GS_OPEN, GS_DONE} asm_gate_e;
  typedef enum logic [1:0] {RS_SIG, RS_EVT, RS_WAVE} asm_rsel_e;
endpackage : asm_pkg
`default_nettype wire

// ===== asm_pod_if.sv
// pod bus between host tester and signature module
`timescale 1ns/1ps
`default_nettype none
interface asm_pod_if;
  logic host_select_strobe;
  logic op_valid;
  logic op_ready;
  logic [7:0] op_code;
  logic rd_valid;
  logic rd_ready;
  logic [3:0] rd_data;
  logic pod_side_handshake;
  modport dev (
    input host_select_strobe, op_valid, op_code, rd_ready,
    output op_ready, rd_valid, rd_data, pod_side_handshake
  );
  modport host (
    output host_select_strobe, op_valid, op_code, rd_ready,
    input op_ready, rd_valid, rd_data, pod_side_handshake
  );
endinterface : asm_pod_if
`default_nettype wire

// ===== asm_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asm_fifo #(
  parameter int W = 4,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : inc

  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    wp_d = push ? inc(wp_q) : wp_q;
    rp_d = pop ? inc(rp_q) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; nothing reads it until written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
endmodule : asm_fifo
`default_nettype wire

// ===== asm_host.sv
// host tester end of the pod bus: select strobe, op codes, result nibbles
`timescale 1ns/1ps
`default_nettype none
module asm_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pod bus
  asm_pod_if.host pod,
  // command port
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  output logic cmd_ready_o,
  // result port
  output logic res_valid_o,
  output logic [asm_pkg::NIB_W-1:0] res_data_o,
  input wire logic res_ready_i,
  // status
  output logic selected_o
);
  import asm_pkg::*;

  // ****************************************************************
  // select strobe and op issue
  // ****************************************************************
  logic sel_q, sel_d, res_v_q, res_v_d, go;
  logic [NIB_W-1:0] res_q, res_d;

  // turn-on waits one cycle, going out in the first cycle the registered strobe is high
  assign go = cmd_valid_i & (sel_q | cmd_op_i != OP_ON);
  assign pod.host_select_strobe = sel_q;
  assign pod.op_valid = go;
  assign pod.op_code = cmd_op_i;
  assign cmd_ready_o = go & pod.op_ready;
  assign pod.rd_ready = ~res_v_q | res_ready_i;

  always_comb begin
    sel_d = sel_q;
    res_v_d = res_v_q;
    res_d = res_q;
    if (cmd_valid_i && cmd_op_i == OP_ON) begin
      sel_d = 1'b1;
    end else if (cmd_ready_o && cmd_op_i == OP_OFF) begin
      sel_d = 1'b0;
    end
    if (res_ready_i) begin
      res_v_d = 1'b0;
    end
    // nibble per step, order kept by the buffer
    if (pod.rd_valid && pod.rd_ready) begin
      res_v_d = 1'b1;
      res_d = pod.rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sel_q <= 1'b0;
      res_v_q <= 1'b0;
      res_q <= '0;
    end else begin
      sel_q <= sel_d;
      res_v_q <= res_v_d;
      res_q <= res_d;
    end
  end

  assign res_valid_o = res_v_q;
  assign res_data_o = res_q;
  assign selected_o = sel_q;
endmodule : asm_host
`default_nettype wire

// ===== asm_monitor.sv
// concurrent checks on the pod bus between host and signature module
`timescale 1ns/1ps
`default_nettype none
module asm_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pod bus
  input wire logic host_select_strobe,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [7:0] op_code,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [3:0] rd_data,
  input wire logic pod_side_handshake
);
  import asm_pkg::*;
  // ****************************************************************
  // sequences
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_take;
    op_valid && op_ready;
  endsequence
  sequence s_take_on;
    s_take ##0 (op_code == OP_ON && host_select_strobe);
  endsequence
  sequence s_take_off;
    s_take ##0 (op_code == OP_OFF && pod_side_handshake);
  endsequence
  // a step only counts while the module owns the pod bus
  sequence s_take_step;
    s_take ##0 (op_code == OP_STEP && pod_side_handshake);
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_select_needs_strobe: assert property (
    $rose(pod_side_handshake) |-> $past(host_select_strobe))
    else $error("select without host strobe");
  a_turn_on_selects: assert property (
    s_take_on |=> pod_side_handshake)
    else $error("turn-on op did not select");
  a_turn_off_frees: assert property (
    s_take_off |=> !pod_side_handshake)
    else $error("turn-off op did not release");
  a_isolate_holds: assert property (
    pod_side_handshake && !(op_valid && op_ready && op_code == OP_OFF)
    |=> pod_side_handshake)
    else $error("pod released without turn-off");
  a_op_held: assert property (
    op_valid && !op_ready |=> op_valid && $stable(op_code))
    else $error("op code dropped before take");
  a_nibble_held: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("result nibble changed before take");
  a_step_answers: assert property (
    s_take_step |-> ##[1:4] rd_valid)
    else $error("step op gave no nibble");
  a_refuse_only_rd: assert property (
    op_valid && !op_ready |->
      pod_side_handshake && (op_code == OP_STATUS || op_code == OP_STEP))
    else $error("op refused outside full result buffer");
  c_turn_on: cover property (s_take_on);
endmodule : asm_monitor
`default_nettype wire

// ===== tb.sv
// self-checking bench joining host and signature module ends
`timescale 1ns/1ps
`default_nettype none
module tb;
  import asm_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_op_i = 8'h00;
  logic res_ready_i = 1'b0;
  logic probe_data_i = 1'b0, ck_clock_i = 1'b0, ck_start_i = 1'b0;
  logic ck_stop_i = 1'b0, ck_enable_i = 1'b1, pod_sync_i = 1'b0;
  logic cmd_ready_o, res_valid_o, selected_o, pod_isolate_o, gate_open_o;
  logic [NIB_W-1:0] res_data_o;
  logic [DLY_W-1:0] delay_sel_o;
  int fail_count = 0;
  int samples_checked = 0;
  logic stalled, g;
  logic [3:0] d;
  logic [SIG_W-1:0] sig_x;
  localparam logic [15:0] PAT_SIG = 16'hB5C3;
  int i, pushed, drained;
  // delay op beside the delay select it should leave
  logic [11:0] rows [8] = '{12'h211, 12'h233, 12'h257, 12'h27F,
                            12'h20E, 12'h22C, 12'h248, 12'h260};
  asm_pod_if pod_if ();
  asm_host i_asm_host (.clk_i(clk_i), .resetn_i(resetn_i), .pod(pod_if),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_ready_o(cmd_ready_o), .res_valid_o(res_valid_o),
    .res_data_o(res_data_o), .res_ready_i(res_ready_i),
    .selected_o(selected_o));
  asm_dev #(.DEPTH(FIFO_DEPTH)) i_asm_dev (.clk_i(clk_i),
    .resetn_i(resetn_i), .pod(pod_if), .probe_data_i(probe_data_i),
    .ck_clock_i(ck_clock_i), .ck_start_i(ck_start_i),
    .ck_stop_i(ck_stop_i), .ck_enable_i(ck_enable_i),
    .pod_sync_i(pod_sync_i), .pod_isolate_o(pod_isolate_o),
    .gate_open_o(gate_open_o), .delay_sel_o(delay_sel_o));
  asm_monitor i_asm_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
    .host_select_strobe(pod_if.host_select_strobe),
    .op_valid(pod_if.op_valid), .op_ready(pod_if.op_ready),
    .op_code(pod_if.op_code), .rd_valid(pod_if.rd_valid),
    .rd_ready(pod_if.rd_ready), .rd_data(pod_if.rd_data),
    .pod_side_handshake(pod_if.pod_side_handshake));
  always #4 clk_i = ~clk_i;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (e !== s) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_n
  // holds the raised op until taken; running out of time is a fault
  task automatic finish_op();
    int n;
    stalled = 1'b1;
    for (n = 0; n < 40 && stalled; n++) begin
      @(negedge clk_i);
      stalled = !cmd_ready_o;
      @(posedge clk_i);
    end
    #1;
    cmd_valid_i = 1'b0;
    chk("op taken", 0, stalled);
  endtask : finish_op
  task automatic send(input logic [7:0] op);
    wait_n(1);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    finish_op();
  endtask : send
  task automatic pop();
    int n;
    g = 1'b0;
    res_ready_i = 1'b1;
    for (n = 0; n < 20 && !g; n++) begin
      @(negedge clk_i);
      g = res_valid_o;
      d = res_data_o;
      @(posedge clk_i);
      #1;
    end
    res_ready_i = 1'b0;
  endtask : pop
  task automatic read(input string nm, input int k, input logic [31:0] e);
    logic [31:0] v;
    int j, cnt;
    v = 32'h0;
    cnt = 0;
    for (j = 0; j < k; j++) begin
      send(OP_STEP);
      pop();
      v = {v[27:0], d};
      cnt = cnt + int'(g);
    end
    if (k > 8) chk(nm, k, cnt);
    else chk(nm, e, v);
  endtask : read
  task automatic pulse(input logic b);
    probe_data_i = b;
    wait_n(2);
    ck_clock_i = 1'b1;
    wait_n(2);
    ck_clock_i = 1'b0;
  endtask : pulse
  task automatic start_edge();
    ck_start_i = 1'b0;
    wait_n(3);
    ck_start_i = 1'b1;
    wait_n(3);
  endtask : start_edge
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #(CLK_NS * 40000);
    fail_count++;
    conclude();
  end
  initial begin
    wait_n(12);
    chk("isolate in reset", 0, pod_isolate_o);
    chk("result in reset", 0, res_valid_o);
    resetn_i = 1'b1;
    send(OP_ON);
    wait_n(3);
    chk("isolate on", 1, pod_isolate_o);
    chk("host selected", 1, selected_o);
    for (i = 0; i < 8; i++) begin
      send(rows[i][11:4]);
      wait_n(2);
      chk("delay select", rows[i][3:0], delay_sel_o);
    end
    foreach (rows[i]) send(8'h11 + 8'(i) * 8'h0);
    send(OP_CLK_MOD);
    send(OP_START_MOD);
    send(OP_STOP_MOD);
    send(OP_CLK_RISE);
    send(OP_START_RISE);
    send(OP_STOP_RISE);
    send(OP_SOC_OFF);
    send(OP_CLR_SIG);
    send(OP_CLR_EVT);
    send(OP_CLR_WAVE);
    send(OP_CLR_GATE);
    send(OP_ARM);
    start_edge();
    chk("gate opens", 1, gate_open_o);
    send(OP_STATUS);
    pop();
    chk("status open", 4'h9, d);
    sig_x = SIG_RST;
    for (i = 0; i < 16; i++) begin
      pulse(PAT_SIG[15 - i]);
      sig_x = {sig_x[14:0], probe_data_i ^ (^(sig_x & SIG_TAPS))};
    end
    ck_stop_i = 1'b1;
    wait_n(4);
    pulse(1'b1);
    chk("gate closes", 0, gate_open_o);
    send(OP_STATUS);
    pop();
    chk("status done", 4'h5, d);
    send(OP_RD_SIG);
    read("signature", 4, sig_x);
    send(OP_RD_EVT);
    read("events", 6, 32'h100000);
    send(OP_RD_WAVE);
    read("wave nibbles", 16, 0);
    ck_stop_i = 1'b0;
    send(OP_CLR_EVT);
    send(OP_CLR_GATE);
    send(OP_SOC_ON);
    send(8'h53);
    send(8'h60);
    send(8'h70);
    send(OP_ARM);
    start_edge();
    // ones leave a non-zero signature, so the clear below is visible
    for (i = 0; i < 5; i++) pulse(1'b1);
    chk("count stop", 0, gate_open_o);
    send(OP_CLR_SIG);
    send(OP_RD_SIG);
    read("cleared signature", 4, SIG_RST);
    send(OP_RD_EVT);
    read("stop count", 6, 32'h030000);
    send(OP_SOC_OFF);
    send(OP_CLR_GATE);
    send(OP_ARM);
    send(OP_DISARM);
    start_edge();
    chk("disarmed", 0, gate_open_o);
    send(OP_ARM);
    start_edge();
    send(OP_CLR_GATE);
    wait_n(2);
    chk("gate reset", 0, gate_open_o);
    pushed = 0;
    for (i = 0; i < 9; i++) begin
      send(OP_STATUS);
      if (!stalled) pushed++;
    end
    // one nibble sits in the host, eight fill the buffer; the next waits
    wait_n(1);
    cmd_valid_i = 1'b1;
    cmd_op_i = OP_STATUS;
    wait_n(4);
    chk("refused", 0, cmd_ready_o);
    pop();
    drained = int'(g);
    finish_op();
    if (!stalled) pushed++;
    g = 1'b1;
    while (g) begin
      pop();
      if (g) drained++;
    end
    chk("drained", pushed, drained);
    send(OP_OFF);
    wait_n(3);
    chk("isolate off", 0, pod_isolate_o);
    send(OP_STATUS);
    pop();
    chk("unselected op", 0, g);
    conclude();
  end
endmodule : tb
`default_nettype wire
